// ---- rtl/dcrf_ram_fifo.sv ----
// Purpose: 4,608-bit storage block usable as dual-port RAM or dual-clock FIFO
// Assumes: clk is the write clock, rdClk the read clock, both free running
// Notes: in FIFO mode the read port follows the write port shape
module dcrf_ram_fifo
(
  input  wire logic                          clk,             // write clock
  input  wire logic                          reset,           // sync reset, write domain
  input  wire logic                          rdClk,           // read clock
  input  wire logic                          clear,           // async clear of the FIFO
  input  wire logic                          fifoMode,        // 1 = FIFO, 0 = RAM
  input  wire logic [dcrf_pkg::SHAPE_W-1:0]  wrShape,         // write port aspect ratio
  input  wire logic [dcrf_pkg::SHAPE_W-1:0]  rdShape,         // read port ratio, RAM mode
  input  wire logic                          rdPipeline,      // 1 = extra read stage
  input  wire logic [dcrf_pkg::PTR_W-1:0]    afThresh,        // almost-full level
  input  wire logic [dcrf_pkg::PTR_W-1:0]    aeThresh,        // almost-empty level
  input  wire logic [dcrf_pkg::BLK_SEL_W-1:0] blockId,        // position in cascade
  input  wire logic                          enPolarity,      // active level of enables
  input  wire dcrf_pkg::dcrf_sel_t           wrSel,           // write enable and upper bits
  input  wire dcrf_pkg::dcrf_sel_t           rdSel,           // read enable and upper bits
  input  wire logic                          writeEn,         // write strobe
  input  wire logic [dcrf_pkg::ADDR_W-1:0]   writeAddrBus,    // RAM write address
  input  wire logic [dcrf_pkg::DATA_W-1:0]   writeDataBus,    // write data, low bits used
  input  wire logic                          readEn,          // read strobe
  input  wire logic [dcrf_pkg::ADDR_W-1:0]   readAddrBus,     // RAM read address
  input  wire logic [dcrf_pkg::DATA_W-1:0]   casRdDataIn,     // read data from prior block
  output logic      [dcrf_pkg::DATA_W-1:0]   rdData,          // this block's read data
  output logic      [dcrf_pkg::DATA_W-1:0]   casRdDataOut,    // read data to next block
  output logic                               full,            // write side flag
  output logic                               almostFullFlag,  // write side flag
  output logic                               empty,           // read side flag
  output logic                               almostEmptyFlag  // read side flag
);

  localparam int               MEM_BITS_W = dcrf_pkg::MEM_BITS;
  localparam int               ADDR_W_MAX = dcrf_pkg::ADDR_W;
  dcrf_pkg::dcrf_mode_t        mode;
  logic [MEM_BITS_W-1:0]       memBits;

  logic [5:0]                  wrWidth;
  logic [5:0]                  rdWidth;
  logic [dcrf_pkg::PTR_W-1:0]  depth;
  logic [dcrf_pkg::ADDR_W-1:0] addrMask;
  logic [dcrf_pkg::ADDR_W-1:0] rdMask;
  logic                        wrPick;
  logic                        rdPick;
  logic                        wrFire;
  logic                        rdFire;
  logic [dcrf_pkg::ADDR_W-1:0] wrAddr;
  logic [dcrf_pkg::ADDR_W-1:0] rdAddr;
  logic [17:0]                 wrProd;
  logic [17:0]                 rdProd;

  logic [dcrf_pkg::PTR_W-1:0]  wrPtr_reg;
  logic [dcrf_pkg::PTR_W-1:0]  wrPtr_next;
  logic [dcrf_pkg::PTR_W-1:0]  wrGray_reg;
  logic [dcrf_pkg::PTR_W-1:0]  wrGray_next;
  logic [dcrf_pkg::PTR_W-1:0]  rdPtr_reg;
  logic [dcrf_pkg::PTR_W-1:0]  rdPtr_next;
  logic [dcrf_pkg::PTR_W-1:0]  rdGray_reg;
  logic [dcrf_pkg::PTR_W-1:0]  rdGray_next;
  logic [dcrf_pkg::PTR_W-1:0]  rdGraySync;
  logic [dcrf_pkg::PTR_W-1:0]  wrGraySync;
  logic [dcrf_pkg::PTR_W-1:0]  rdPtrAtWr;
  logic [dcrf_pkg::PTR_W-1:0]  wrPtrAtRd;
  logic [dcrf_pkg::PTR_W-1:0]  wrLevel;
  logic [dcrf_pkg::PTR_W-1:0]  rdLevel;
  dcrf_pkg::dcrf_flags_t       wrFlags_reg;
  dcrf_pkg::dcrf_flags_t       wrFlags_next;
  dcrf_pkg::dcrf_flags_t       rdFlags_reg;
  dcrf_pkg::dcrf_flags_t       rdFlags_next;

  logic                        rdRstMeta_reg;
  logic                        rdReset_reg;
  logic [dcrf_pkg::DATA_W-1:0] rdWord_reg;
  logic [dcrf_pkg::DATA_W-1:0] rdWord_next;
  logic [dcrf_pkg::DATA_W-1:0] rdPipe_reg;
  logic [dcrf_pkg::DATA_W-1:0] rdPipe_next;
  logic                        rdOwn_reg;
  logic                        rdOwn_next;

  // shared configuration: in FIFO mode both ports run at the write shape
  always_comb
  begin
    mode     = fifoMode ? dcrf_pkg::DCRF_FIFO : dcrf_pkg::DCRF_RAM;
    wrWidth  = dcrf_pkg::dcrf_width(wrShape);
    rdWidth  = fifoMode ? wrWidth : dcrf_pkg::dcrf_width(rdShape);
    depth    = dcrf_pkg::dcrf_depth(wrShape);
    addrMask = ADDR_W_MAX'(depth - 13'h0001);
    // a RAM read port of another shape must stay inside the array
    rdMask   = fifoMode ? addrMask
                        : ADDR_W_MAX'(dcrf_pkg::dcrf_depth(rdShape) - 13'h0001);
  end

  // cascade decode: only the addressed block with its enable at the set level acts
  always_comb
  begin
    wrPick = (wrSel.enable == enPolarity) && (wrSel.addrHi == blockId);
    rdPick = (rdSel.enable == enPolarity) && (rdSel.addrHi == blockId);
  end

  // write domain
  always_comb
  begin
    wrAddr       = writeAddrBus & addrMask;
    wrFire       = writeEn && wrPick;
    wrPtr_next   = wrPtr_reg;
    case (mode)
      dcrf_pkg::DCRF_FIFO:
      begin
        wrAddr = wrPtr_reg[dcrf_pkg::ADDR_W-1:0] & addrMask;
        wrFire = writeEn && wrPick && !wrFlags_reg.full;
        if (wrFire)
        begin
          wrPtr_next = wrPtr_reg + 13'h0001;
        end
      end
      dcrf_pkg::DCRF_RAM:
      begin
        wrAddr = writeAddrBus & addrMask;
      end
      default:
      begin
        wrFire = 1'b0;
      end
    endcase
    wrProd       = {6'h00, wrAddr} * {12'h000, wrWidth};
    wrGray_next  = dcrf_pkg::dcrf_to_gray(wrPtr_next);
    rdPtrAtWr    = dcrf_pkg::dcrf_from_gray(rdGraySync);
    wrLevel      = wrPtr_next - rdPtrAtWr;
    wrFlags_next = wrFlags_reg;
    wrFlags_next.full       = (wrLevel >= depth);
    wrFlags_next.almostFull = (wrLevel >= afThresh);
    if (reset)
    begin
      wrPtr_next   = dcrf_pkg::PTR_RESET;
      wrGray_next  = dcrf_pkg::PTR_RESET;
      wrFlags_next = dcrf_pkg::FLAGS_CLEAR;
    end
  end

  always_ff @(posedge clk or posedge clear)
  begin
    if (clear)
    begin
      wrPtr_reg   <= dcrf_pkg::PTR_RESET;
      wrGray_reg  <= dcrf_pkg::PTR_RESET;
      wrFlags_reg <= dcrf_pkg::FLAGS_CLEAR;
    end
    else
    begin
      wrPtr_reg   <= wrPtr_next;
      wrGray_reg  <= wrGray_next;
      wrFlags_reg <= wrFlags_next;
    end
  end

  // storage written bit by bit so any port width packs into the same array
  always_ff @(posedge clk)
  begin
    if (wrFire)
    begin
      for (int i = 0; i < dcrf_pkg::DATA_W; i++)
      begin
        if (i < int'(wrWidth))
        begin
          memBits[int'(wrProd[12:0]) + i] <= writeDataBus[i];
        end
      end
    end
  end

  // pointers cross as gray code, one bit changes per step
  dcrf_gray_sync u_rd_to_wr
  (
    .clk     (clk),
    .reset   (reset),
    .clear   (clear),
    .grayIn  (rdGray_reg),
    .grayOut (rdGraySync)
  );

  dcrf_gray_sync u_wr_to_rd
  (
    .clk     (rdClk),
    .reset   (rdReset_reg),
    .clear   (clear),
    .grayIn  (wrGray_reg),
    .grayOut (wrGraySync)
  );

  // reset level carried into the read domain
  always_ff @(posedge rdClk or posedge clear)
  begin
    if (clear)
    begin
      rdRstMeta_reg <= 1'b0;
      rdReset_reg   <= 1'b0;
    end
    else
    begin
      rdRstMeta_reg <= reset;
      rdReset_reg   <= rdRstMeta_reg;
    end
  end

  // read domain
  always_comb
  begin
    rdAddr     = readAddrBus & rdMask;
    rdFire     = readEn && rdPick;
    rdPtr_next = rdPtr_reg;
    case (mode)
      dcrf_pkg::DCRF_FIFO:
      begin
        rdAddr = rdPtr_reg[dcrf_pkg::ADDR_W-1:0] & addrMask;
        rdFire = readEn && rdPick && !rdFlags_reg.empty;
        if (rdFire)
        begin
          rdPtr_next = rdPtr_reg + 13'h0001;
        end
      end
      dcrf_pkg::DCRF_RAM:
      begin
        rdAddr = readAddrBus & rdMask;
      end
      default:
      begin
        rdFire = 1'b0;
      end
    endcase
    rdProd      = {6'h00, rdAddr} * {12'h000, rdWidth};
    rdWord_next = rdWord_reg;
    if (rdFire)
    begin
      for (int i = 0; i < dcrf_pkg::DATA_W; i++)
      begin
        rdWord_next[i] = (i < int'(rdWidth)) ? memBits[int'(rdProd[12:0]) + i] : 1'b0;
      end
    end
    rdOwn_next   = rdFire ? 1'b1 : ((readEn && !rdPick) ? 1'b0 : rdOwn_reg);
    rdPipe_next  = rdWord_reg;
    rdGray_next  = dcrf_pkg::dcrf_to_gray(rdPtr_next);
    wrPtrAtRd    = dcrf_pkg::dcrf_from_gray(wrGraySync);
    rdLevel      = wrPtrAtRd - rdPtr_next;
    rdFlags_next = rdFlags_reg;
    rdFlags_next.empty       = (rdLevel == dcrf_pkg::PTR_RESET);
    rdFlags_next.almostEmpty = (rdLevel <= aeThresh);
    if (rdReset_reg)
    begin
      rdPtr_next   = dcrf_pkg::PTR_RESET;
      rdGray_next  = dcrf_pkg::PTR_RESET;
      rdFlags_next = dcrf_pkg::FLAGS_CLEAR;
      rdWord_next  = dcrf_pkg::DATA_RESET;
      rdPipe_next  = dcrf_pkg::DATA_RESET;
      rdOwn_next   = 1'b0;
    end
  end

  always_ff @(posedge rdClk or posedge clear)
  begin
    if (clear)
    begin
      rdPtr_reg   <= dcrf_pkg::PTR_RESET;
      rdGray_reg  <= dcrf_pkg::PTR_RESET;
      rdFlags_reg <= dcrf_pkg::FLAGS_CLEAR;
      rdWord_reg  <= dcrf_pkg::DATA_RESET;
      rdPipe_reg  <= dcrf_pkg::DATA_RESET;
      rdOwn_reg   <= 1'b0;
    end
    else
    begin
      rdPtr_reg   <= rdPtr_next;
      rdGray_reg  <= rdGray_next;
      rdFlags_reg <= rdFlags_next;
      rdWord_reg  <= rdWord_next;
      rdPipe_reg  <= rdPipe_next;
      rdOwn_reg   <= rdOwn_next;
    end
  end

  // the chain is plain muxing, no fabric logic between blocks
  always_comb
  begin
    rdData          = rdPipeline ? rdPipe_reg : rdWord_reg;
    casRdDataOut    = rdOwn_reg ? rdData : casRdDataIn;
    full            = wrFlags_reg.full;
    almostFullFlag  = wrFlags_reg.almostFull;
    empty           = rdFlags_reg.empty;
    almostEmptyFlag = rdFlags_reg.almostEmpty;
  end

  a_full_blocks_write: assert property (@(posedge clk) disable iff (reset || clear)
    fifoMode && full && writeEn |=> $stable(wrPtr_reg))
    else $error("write pointer moved while full");

  a_empty_blocks_read: assert property (@(posedge rdClk) disable iff (rdReset_reg || clear)
    fifoMode && empty && readEn |=> $stable(rdPtr_reg))
    else $error("read pointer moved while empty");

  a_wr_ptr_step: assert property (@(posedge clk) disable iff (reset || clear)
    fifoMode && writeEn && wrPick && !full |=> wrPtr_reg == $past(wrPtr_reg) + 13'h0001)
    else $error("write pointer did not advance by one");

  a_ram_ptr_idle: assert property (@(posedge clk) disable iff (reset || clear)
    !fifoMode ##1 !fifoMode |-> $stable(wrPtr_reg))
    else $error("write pointer moved in RAM mode");

  a_deselect_no_write: assert property (@(posedge clk) disable iff (reset || clear)
    writeEn && !wrPick |=> $stable(wrPtr_reg))
    else $error("unselected block accepted a write");

  a_empty_implies_ae: assert property (@(posedge rdClk) disable iff (rdReset_reg || clear)
    empty |-> almostEmptyFlag || (aeThresh != $past(aeThresh)))
    else $error("empty without almost-empty");

  a_pipe_stage_delay: assert property (@(posedge rdClk) disable iff (rdReset_reg || clear)
    rdPipeline && $past(rdPipeline) |-> rdData == $past(rdWord_reg))
    else $error("pipelined data not one stage late");

  a_clear_sets_flags: assert property (@(posedge clk) disable iff (reset)
    clear |-> !full && !almostFullFlag && wrPtr_reg == 13'h0000)
    else $error("clear did not reset write side");

  a_fifo_width_match: assert property (@(posedge rdClk) disable iff (rdReset_reg || clear)
    fifoMode |-> rdWidth == wrWidth)
    else $error("FIFO read width differs from write width");

  a_cascade_pass: assert property (@(posedge rdClk) disable iff (rdReset_reg || clear)
    !rdOwn_reg |-> casRdDataOut == casRdDataIn)
    else $error("cascade data not passed through");

endmodule : dcrf_ram_fifo

// ---- rtl/dcrf_pkg.sv ----
// Purpose: shared constants, types and helpers for the dual-clock RAM/FIFO block
// Assumes: one storage array of 4,608 bits, one write clock and one read clock
// Notes: shape codes select the array aspect ratio on each port
//
// Notes on behaviour
// - the block holds 4,608 bits and works either as a RAM or as a FIFO.
// - writes and reads are synchronous, each on its own fully independent clock.
// - in FIFO mode the controller makes the storage addresses and the four status flags.
// - the FIFO guards against metastability, refuses writes when full and reads when empty.
// - in RAM mode user logic supplies both addresses and the FIFO controller is ignored.
// - in FIFO mode internal multiplexers route the controller pointers to the array.
// - an enable with selectable polarity plus upper address bits selects one of up to 16 blocks.
// - cascaded blocks share write and read address, data and enable buses internally.
// - cascade links need no extra fabric logic; read data simply chains from block to block.
// - the aspect ratio is one of 128x36, 256x18, 512x9, 1kx4, 2kx2 or 4kx1.
// - read and write ports may use different widths, so data comes back at another width; in FIFO mode the code reads at the write width.
// - the almost-empty and almost-full thresholds are programmable.
// - the FIFO width and depth are set by configuration.
package dcrf_pkg;

  localparam int MEM_BITS   = 4608;
  localparam int DATA_W     = 36;
  localparam int ADDR_W     = 12;
  localparam int PTR_W      = 13;
  localparam int SHAPE_W    = 3;
  localparam int BLK_SEL_W  = 4;
  localparam int SYNC_DEPTH = 2;

  localparam logic [SHAPE_W-1:0] SHAPE_128X36 = 3'h0;
  localparam logic [SHAPE_W-1:0] SHAPE_256X18 = 3'h1;
  localparam logic [SHAPE_W-1:0] SHAPE_512X9  = 3'h2;
  localparam logic [SHAPE_W-1:0] SHAPE_1KX4   = 3'h3;
  localparam logic [SHAPE_W-1:0] SHAPE_2KX2   = 3'h4;
  localparam logic [SHAPE_W-1:0] SHAPE_4KX1   = 3'h5;

  localparam logic [PTR_W-1:0]  PTR_RESET  = 13'h0000;
  localparam logic [PTR_W-1:0]  BASE_DEPTH = 13'h0080;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;

  typedef enum logic [1:0] {
    DCRF_RAM  = 2'h1,
    DCRF_FIFO = 2'h2
  } dcrf_mode_t;

  typedef struct packed {
    logic full;
    logic almostFull;
    logic empty;
    logic almostEmpty;
  } dcrf_flags_t;

  localparam dcrf_flags_t FLAGS_CLEAR = '{full: 1'b0, almostFull: 1'b0,
                                          empty: 1'b1, almostEmpty: 1'b1};

  typedef struct packed {
    logic                 enable;
    logic [BLK_SEL_W-1:0] addrHi;
  } dcrf_sel_t;

  function automatic logic [5:0] dcrf_width(input logic [SHAPE_W-1:0] shape);
    case (shape)
      SHAPE_128X36: dcrf_width = 6'h24;
      SHAPE_256X18: dcrf_width = 6'h12;
      SHAPE_512X9:  dcrf_width = 6'h09;
      SHAPE_1KX4:   dcrf_width = 6'h04;
      SHAPE_2KX2:   dcrf_width = 6'h02;
      default:      dcrf_width = 6'h01;
    endcase
  endfunction : dcrf_width

  function automatic logic [PTR_W-1:0] dcrf_depth(input logic [SHAPE_W-1:0] shape);
    logic [SHAPE_W-1:0] s;
    s          = (shape > SHAPE_4KX1) ? SHAPE_4KX1 : shape;
    dcrf_depth = BASE_DEPTH << s;
  endfunction : dcrf_depth

  function automatic logic [PTR_W-1:0] dcrf_to_gray(input logic [PTR_W-1:0] b);
    dcrf_to_gray = b ^ (b >> 1);
  endfunction : dcrf_to_gray

  function automatic logic [PTR_W-1:0] dcrf_from_gray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    dcrf_from_gray = b;
  endfunction : dcrf_from_gray

endpackage : dcrf_pkg

// ---- rtl/dcrf_gray_sync.sv ----
// Purpose: two-stage synchroniser for a gray-coded pointer
// Assumes: input changes by at most one bit per source clock
// Notes: clear acts asynchronously; reset is synchronous to the destination clock
module dcrf_gray_sync
(
  input  wire logic                      clk,      // destination clock
  input  wire logic                      reset,    // synchronous reset, high
  input  wire logic                      clear,    // asynchronous clear, high
  input  wire logic [dcrf_pkg::PTR_W-1:0] grayIn,  // pointer from other domain
  output logic      [dcrf_pkg::PTR_W-1:0] grayOut  // synchronised pointer
);

  logic [dcrf_pkg::PTR_W-1:0] meta_reg;
  logic [dcrf_pkg::PTR_W-1:0] meta_next;
  logic [dcrf_pkg::PTR_W-1:0] stable_reg;
  logic [dcrf_pkg::PTR_W-1:0] stable_next;

  // first stage feeds only the second stage
  always_comb
  begin
    meta_next   = reset ? dcrf_pkg::PTR_RESET : grayIn;
    stable_next = reset ? dcrf_pkg::PTR_RESET : meta_reg;
  end

  always_ff @(posedge clk or posedge clear)
  begin
    if (clear)
    begin
      meta_reg   <= dcrf_pkg::PTR_RESET;
      stable_reg <= dcrf_pkg::PTR_RESET;
    end
    else
    begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
    end
  end

  assign grayOut = stable_reg;

endmodule : dcrf_gray_sync

// ---- dv/dcrf_fabric_reader.sv ----
// Purpose: fabric-side reader model driving the read port of the storage block
// Assumes: rdClk runs free; requests change just after its falling edge
// Notes: FIFO drains stall on an 8-bit lfsr; idle address lines toggle like a released bus
module dcrf_fabric_reader
(
  input  wire logic        rdClk,       // read clock
  input  wire logic        go,          // run while high
  input  wire logic        fifoRun,     // 1 = drain with stalls, 0 = RAM sweep
  input  wire logic [7:0]  nReads,      // words in one RAM sweep
  output logic             readEn = 1'b0,          // read strobe
  output logic [11:0]      readAddrBus = 12'h000   // sweep address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] stall = 8'hA5;
  int         cnt   = 0;
  always @(negedge rdClk)
  begin
    stall = {stall[6:0], stall[7] ^ stall[5] ^ stall[4] ^ stall[3]};
    if (go !== 1'b1)
    begin
      cnt = 0;
      readEn <= 1'b0;
      readAddrBus <= ~readAddrBus;
    end
    else if (fifoRun)
    begin
      // empty is not looked at: the block itself has to refuse
      readEn <= stall[0] | stall[1];
      readAddrBus <= ~readAddrBus;
    end
    else
    begin
      readEn <= (cnt < nReads);
      readAddrBus <= cnt[11:0];
      cnt++;
    end
  end
endmodule : dcrf_fabric_reader

// ---- dv/tb_dcrf_ram_fifo.sv ----
// Purpose: self-checking bench for the RAM/FIFO storage block
// Assumes: write side driven on falling clk, reads made by the fabric reader model
// Notes: read results are matched in order against a queue of expected words
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_dcrf_ram_fifo;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WID [6] = '{36, 18, 9, 4, 2, 1};
  logic clk = 1'b0, rdClk = 1'b0, reset = 1'b1, clear = 1'b0, fifoMode = 1'b0;
  logic rdPipeline = 1'b0, enPolarity = 1'b1, writeEn = 1'b0, rdGo = 1'b0, fifoRun = 1'b0;
  logic [2:0] wrShape = 3'h0, rdShape = 3'h0;
  logic [12:0] afThresh = 13'h01F4, aeThresh = 13'h0004;
  logic [11:0] writeAddrBus = 12'h000, readAddrBus;
  logic [35:0] writeDataBus = 36'h000000000, casRdDataIn = 36'h000000000;
  logic [35:0] rdData, casRdDataOut, hold, expWord;
  logic full, almostFullFlag, empty, almostEmptyFlag, readEn, acc1 = 1'b0, acc2 = 1'b0;
  logic [7:0] nReads = 8'h00;
  dcrf_pkg::dcrf_sel_t wrSel = 5'h13, rdSel = 5'h13;
  logic [31:0] seed = 32'h47DA9743;
  logic mem [0:4607];
  logic [35:0] expQ[$];
  int num_errors = 0, total_checks = 0;

  dcrf_ram_fifo u_dcrf_ram_fifo (.clk, .reset, .rdClk, .clear, .fifoMode, .wrShape, .rdShape,
    .rdPipeline, .afThresh, .aeThresh, .blockId(4'h3), .enPolarity, .wrSel, .rdSel, .writeEn,
    .writeAddrBus, .writeDataBus, .readEn, .readAddrBus, .casRdDataIn, .rdData, .casRdDataOut,
    .full, .almostFullFlag, .empty, .almostEmptyFlag);
  dcrf_fabric_reader u_dcrf_fabric_reader (.rdClk, .go(rdGo), .fifoRun, .nReads, .readEn,
    .readAddrBus);

  always #20 clk = ~clk;
  always #17 rdClk = ~rdClk;
  always @(negedge clk) casRdDataIn <= ~casRdDataIn;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // a result is checked at the falling edge after the taking edge, one read clock later when pipelined
  always @(posedge rdClk)
  begin
    acc1 <= readEn && (!fifoMode || empty === 1'b0);
    acc2 <= acc1;
  end
  always @(negedge rdClk)
  begin
    if (rdPipeline ? acc2 : acc1)
    begin
      if (expQ.size() == 0)
      begin
        num_errors++;
        $display("unexpected at %0t: read result with nothing expected", $time);
      end
      else
      begin
        expWord = expQ.pop_front();
        `CHK(rdData, expWord)
        `CHK(casRdDataOut, rdData)
      end
    end
  end

  task automatic wr(input logic [11:0] a, input logic [35:0] d, input dcrf_pkg::dcrf_sel_t s);
    @(negedge clk);
    writeEn = 1'b1;
    writeAddrBus = a;
    writeDataBus = d;
    wrSel = s;
    @(negedge clk);
    writeEn = 1'b0;
  endtask : wr

  task automatic run_reader(input logic [7:0] n, input logic fifo);
    nReads = n;
    fifoRun = fifo;
    rdGo = 1'b1;
    for (int t = 0; t < 4000 && expQ.size() != 0; t++)
      @(negedge clk);
    if (expQ.size() != 0)
    begin
      num_errors++;
      $display("unexpected at %0t: read results missing", $time);
      final_report();
    end
    hold = rdData;
    repeat (10) @(negedge clk);
    `CHK(rdData, hold)
    rdGo = 1'b0;
    repeat (4) @(negedge clk);
  endtask : run_reader

  task automatic ram_case(input int ws, input int rs, input int nw, input int nr);
    logic [35:0] d;
    logic [35:0] e;
    @(negedge clk);
    wrShape = ws[2:0];
    rdShape = rs[2:0];
    rdPipeline = ws[0];
    enPolarity = ws[1];
    rdSel = {ws[1], 4'h3};
    for (int a = 0; a < nw; a++)
    begin
      seed = lfsr_next(seed);
      d = {seed[3:0], seed};
      wr(a[11:0], d, {ws[1], 4'h3});
      for (int k = 0; k < WID[ws]; k++)
        mem[a * WID[ws] + k] = d[k];
    end
    wr(12'h000, ~d, {ws[1], 4'h2});
    wr(12'h000, ~d, {~ws[1], 4'h3});
    for (int r = 0; r < nr; r++)
    begin
      e = '0;
      for (int k = 0; k < WID[rs]; k++)
        e[k] = mem[r * WID[rs] + k];
      expQ.push_back(e);
    end
    run_reader(nr[7:0], 1'b0);
    $display("test ram shape %0d read as %0d done", ws, rs);
  endtask : ram_case

  task automatic fifo_fill();
    int nAcc;
    nAcc = 0;
    for (int i = 0; i < 514; i++)
    begin
      @(negedge clk);
      if (nAcc == 499) `CHK(almostFullFlag, 1'b0)
      if (nAcc == 500) `CHK(almostFullFlag, 1'b1)
      if (nAcc == 511) `CHK(full, 1'b0)
      seed = lfsr_next(seed);
      writeEn = 1'b1;
      writeAddrBus = seed[11:0];
      writeDataBus = {seed[3:0], seed};
      if (full === 1'b0)
      begin
        expQ.push_back(writeDataBus & 36'h0000001FF);
        nAcc++;
      end
    end
    @(negedge clk);
    writeEn = 1'b0;
    `CHK(nAcc, 512)
    `CHK(full, 1'b1)
    $display("test fifo fill done");
  endtask : fifo_fill

  task automatic pulse_clear();
    @(negedge clk);
    #5 clear = 1'b1;
    #1;
    `CHK(empty, 1'b1)
    `CHK(almostEmptyFlag, 1'b1)
    `CHK(full, 1'b0)
    `CHK(almostFullFlag, 1'b0)
    expQ.delete();
    @(negedge clk);
    clear = 1'b0;
  endtask : pulse_clear

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    `CHK(empty, 1'b1)
    `CHK(almostEmptyFlag, 1'b1)
    `CHK(full, 1'b0)
    `CHK(almostFullFlag, 1'b0)
    `CHK(rdData, 36'h000000000)
    `CHK(casRdDataOut, casRdDataIn)
    $display("test reset done");
    for (int s = 0; s < 6; s++)
      ram_case(s, s, 4, 4);
    ram_case(3, 5, 4, 16);
    ram_case(5, 2, 18, 2);
    @(negedge clk);
    fifoMode = 1'b1;
    wrShape = 3'h2;
    rdPipeline = 1'b1;
    enPolarity = 1'b1;
    rdSel = 5'h13;
    wrSel = 5'h13;
    pulse_clear();
    fifo_fill();
    repeat (8) @(negedge clk);
    `CHK(empty, 1'b0)
    `CHK(almostEmptyFlag, 1'b0)
    run_reader(8'h00, 1'b1);
    `CHK(empty, 1'b1)
    `CHK(almostEmptyFlag, 1'b1)
    `CHK(full, 1'b0)
    $display("test fifo drain done");
    fifo_fill();
    pulse_clear();
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr_next(seed);
      wr(seed[11:0], {seed[3:0], seed}, 5'h13);
      expQ.push_back({seed[3:0], seed} & 36'h0000001FF);
    end
    run_reader(8'h00, 1'b1);
    $display("test fifo clear done");
    final_report();
  end

  initial
  begin
    #2000000;
    num_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    final_report();
  end
endmodule : tb_dcrf_ram_fifo
